// file: rtl/psi_ctrl.v
`timescale 1ns/1ps
`default_nettype none
`include "psi_defs.vh"

// Functional notes
// - Read drives select, output enable, byte selects low; write enable, sleep high.
// - Write drives select, write enable, byte selects low; sleep stays high.
// - Write enable low time stays below the maximum select-low time.
// - Sleep low with select high enters a low-power mode.
// - With sleep low, select and write enable low load the config.
// - Controller keeps select high during initialisation, accesses afterwards.
// - Low-power mode only after sleep held low over 10us.
module psi_ctrl (
    input  wire        ref_clk,
    input  wire        rst,
    input  wire [5:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [5:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    output reg         chip_select_n,
    output reg         output_enable_n,
    output reg         write_enable_n,
    output reg         lower_byte_sel_n,
    output reg         upper_byte_sel_n,
    output reg         sleep_n,
    output reg  [21:0] addr_in,
    output reg  [15:0] data_io_out,
    output reg         data_io_oe,
    input  wire [15:0] data_io_in
);

    localparam [3:0] ST_INIT = 4'h0;
    localparam [3:0] ST_IDLE = 4'h1;
    localparam [3:0] ST_RD   = 4'h2;
    localparam [3:0] ST_WR   = 4'h3;
    localparam [3:0] ST_WEND = 4'h4;
    localparam [3:0] ST_CFG0 = 4'h5;
    localparam [3:0] ST_CFG1 = 4'h6;
    localparam [3:0] ST_CFG2 = 4'h7;
    localparam [3:0] ST_SLP  = 4'h8;
    localparam [3:0] ST_REL  = 4'h9;

    localparam integer ACC_INT  = `PSI_ACC_CYC + `PSI_SYNC_CYC;
    localparam integer WE_INT   = `PSI_WE_CYC;
    localparam integer INIT_INT = `PSI_INIT_CYC;
    localparam integer SLP_INT  = `PSI_SLP_CYC;
    // Counts narrowed on purpose to the width of the shared counter
    localparam [10:0] ACC_CYC  = ACC_INT[10:0];
    localparam [10:0] WE_CYC   = WE_INT[10:0];
    localparam [10:0] INIT_CYC = INIT_INT[10:0];
    localparam [10:0] SLP_CYC  = SLP_INT[10:0];
    localparam [10:0] ONE      = 11'h001;

    reg  [3:0]  state_reg;
    reg  [10:0] cnt_reg;
    reg  [2:0]  cmd_reg;
    reg         sleep_req_reg;
    reg         lowpwr_reg;
    reg         ready_reg;
    reg         done_reg;
    reg  [21:0] addr_reg;
    reg  [17:0] wdata_reg;
    reg  [15:0] rdata_reg;
    reg  [21:0] cfg_reg;
    reg  [21:0] cfg_live_reg;
    reg  [15:0] din_meta_reg;
    reg  [15:0] din_sync_reg;
    reg         aw_have_reg;
    reg         w_have_reg;
    reg  [5:0]  aw_addr_reg;
    reg  [31:0] w_data_reg;
    reg  [3:0]  w_strb_reg;
    reg  [31:0] rd_mux;
    reg         rd_hit;

    wire        wr_fire = aw_have_reg && w_have_reg && !s_axi_bvalid;
    wire        wr_hit  = (aw_addr_reg == `PSI_OFS_CTRL) || (aw_addr_reg == `PSI_OFS_ADDR) ||
                          (aw_addr_reg == `PSI_OFS_WDATA) || (aw_addr_reg == `PSI_OFS_CFG) ||
                          (aw_addr_reg == `PSI_OFS_STATUS) || (aw_addr_reg == `PSI_OFS_RDATA);
    wire        busy    = (state_reg != ST_IDLE) || (cmd_reg != 3'h0);
    wire [31:0] wmask   = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}},
                           {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
    wire [31:0] addr_m  = ({10'h000, addr_reg} & ~wmask) | (w_data_reg & wmask);
    wire [31:0] wdat_m  = ({14'h0000, wdata_reg} & ~wmask) | (w_data_reg & wmask);
    wire [31:0] cfg_m   = ({10'h000, cfg_reg} & ~wmask) | (w_data_reg & wmask);

    always @* begin
        rd_hit = 1'b1;
        case (s_axi_araddr)
            `PSI_OFS_CTRL:   rd_mux = {28'h0000000, sleep_req_reg, cmd_reg};
            `PSI_OFS_ADDR:   rd_mux = {10'h000, addr_reg};
            `PSI_OFS_WDATA:  rd_mux = {14'h0000, wdata_reg};
            `PSI_OFS_RDATA:  rd_mux = {16'h0000, rdata_reg};
            `PSI_OFS_CFG:    rd_mux = {10'h000, cfg_reg};
            `PSI_OFS_STATUS: rd_mux = {28'h0000000, done_reg, lowpwr_reg, ready_reg, busy};
            default: begin
                rd_mux = 32'h00000000;
                rd_hit = 1'b0;
            end
        endcase
    end

    // Data pins cross into the clock domain through two flops
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            din_meta_reg <= 16'h0000;
            din_sync_reg <= 16'h0000;
        end else begin
            din_meta_reg <= data_io_in;
            din_sync_reg <= din_meta_reg;
        end
    end

    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `PSI_RESP_OK;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rresp   <= `PSI_RESP_OK;
            s_axi_rdata   <= 32'h00000000;
            aw_have_reg   <= 1'b0;
            w_have_reg    <= 1'b0;
            aw_addr_reg   <= 6'h00;
            w_data_reg    <= 32'h00000000;
            w_strb_reg    <= 4'h0;
            state_reg     <= ST_INIT;
            cnt_reg       <= 11'h000;
            cmd_reg       <= 3'h0;
            sleep_req_reg <= 1'b0;
            lowpwr_reg    <= 1'b0;
            ready_reg     <= 1'b0;
            done_reg      <= 1'b0;
            addr_reg      <= 22'h000000;
            wdata_reg     <= 18'h30000;
            rdata_reg     <= 16'h0000;
            cfg_reg       <= `PSI_CFG_RESET;
            cfg_live_reg  <= `PSI_CFG_RESET;
            chip_select_n    <= 1'b1;
            output_enable_n  <= 1'b1;
            write_enable_n   <= 1'b1;
            lower_byte_sel_n <= 1'b1;
            upper_byte_sel_n <= 1'b1;
            sleep_n          <= 1'b1;
            addr_in          <= 22'h000000;
            data_io_out      <= 16'h0000;
            data_io_oe       <= 1'b0;
        end else begin
            // Ready is registered from a clear holding flag and a waiting valid: one beat per two cycles
            s_axi_awready <= !aw_have_reg && !s_axi_awready && s_axi_awvalid;
            s_axi_wready  <= !w_have_reg && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_mux;
                s_axi_rresp  <= rd_hit ? `PSI_RESP_OK : `PSI_RESP_ERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
            if (wr_fire) begin
                aw_have_reg  <= 1'b0;
                w_have_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? `PSI_RESP_OK : `PSI_RESP_ERR;
                case (aw_addr_reg)
                    `PSI_OFS_CTRL: begin
                        if (w_strb_reg[0]) begin
                            sleep_req_reg <= w_data_reg[`PSI_CTRL_SLP];
                            // Read, write and config orders arriving while busy are dropped
                            if (!busy) begin
                                cmd_reg <= w_data_reg[`PSI_CTRL_CFG:`PSI_CTRL_RD];
                            end
                        end
                    end
                    `PSI_OFS_ADDR:   addr_reg  <= addr_m[21:0];
                    `PSI_OFS_WDATA:  wdata_reg <= wdat_m[17:0];
                    `PSI_OFS_CFG:    cfg_reg   <= cfg_m[21:0];
                    `PSI_OFS_STATUS: begin
                        if (w_strb_reg[0] && w_data_reg[`PSI_ST_DONE]) begin
                            done_reg <= 1'b0;
                        end
                    end
                    default: begin
                    end
                endcase
            end

            case (state_reg)
                ST_INIT: begin
                    chip_select_n <= 1'b1;
                    ready_reg     <= 1'b0;
                    if (cnt_reg >= INIT_CYC - ONE) begin
                        cnt_reg   <= 11'h000;
                        ready_reg <= 1'b1;
                        state_reg <= ST_IDLE;
                    end else begin
                        cnt_reg <= cnt_reg + ONE;
                    end
                end
                ST_IDLE: begin
                    cnt_reg <= 11'h000;
                    addr_in <= addr_reg;
                    if (sleep_req_reg) begin
                        sleep_n   <= 1'b0;
                        state_reg <= ST_SLP;
                    end else if (cmd_reg[`PSI_CTRL_CFG]) begin
                        state_reg <= ST_CFG0;
                    end else if (cmd_reg[`PSI_CTRL_WR]) begin
                        chip_select_n    <= 1'b0;
                        write_enable_n   <= 1'b0;
                        lower_byte_sel_n <= !wdata_reg[`PSI_WD_LB];
                        upper_byte_sel_n <= !wdata_reg[`PSI_WD_UB];
                        data_io_out      <= wdata_reg[15:0];
                        data_io_oe       <= 1'b1;
                        state_reg        <= ST_WR;
                    end else if (cmd_reg[`PSI_CTRL_RD]) begin
                        chip_select_n    <= 1'b0;
                        output_enable_n  <= 1'b0;
                        lower_byte_sel_n <= !wdata_reg[`PSI_WD_LB];
                        upper_byte_sel_n <= !wdata_reg[`PSI_WD_UB];
                        state_reg        <= ST_RD;
                    end
                end
                ST_RD: begin
                    if (cnt_reg >= ACC_CYC - ONE) begin
                        rdata_reg       <= din_sync_reg;
                        chip_select_n   <= 1'b1;
                        output_enable_n <= 1'b1;
                        lower_byte_sel_n <= 1'b1;
                        upper_byte_sel_n <= 1'b1;
                        state_reg       <= ST_REL;
                    end else begin
                        cnt_reg <= cnt_reg + ONE;
                    end
                end
                ST_WR: begin
                    if (cnt_reg >= WE_CYC - ONE) begin
                        chip_select_n    <= 1'b1;
                        write_enable_n   <= 1'b1;
                        lower_byte_sel_n <= 1'b1;
                        upper_byte_sel_n <= 1'b1;
                        state_reg        <= ST_WEND;
                    end else begin
                        cnt_reg <= cnt_reg + ONE;
                    end
                end
                ST_WEND: begin
                    // Data held one cycle past the rising edges for hold time
                    data_io_oe <= 1'b0;
                    state_reg  <= ST_REL;
                end
                ST_CFG0: begin
                    sleep_n   <= 1'b0;
                    addr_in   <= cfg_reg;
                    cnt_reg   <= 11'h000;
                    state_reg <= ST_CFG1;
                end
                ST_CFG1: begin
                    chip_select_n  <= 1'b0;
                    write_enable_n <= 1'b0;
                    if (cnt_reg >= WE_CYC) begin
                        chip_select_n  <= 1'b1;
                        write_enable_n <= 1'b1;
                        cfg_live_reg   <= addr_in;
                        state_reg      <= ST_CFG2;
                    end else begin
                        cnt_reg <= cnt_reg + ONE;
                    end
                end
                ST_CFG2: begin
                    sleep_n   <= 1'b1;
                    state_reg <= ST_REL;
                end
                ST_SLP: begin
                    if (cnt_reg >= SLP_CYC) begin
                        lowpwr_reg <= 1'b1;
                    end else begin
                        cnt_reg <= cnt_reg + ONE;
                    end
                    if (!sleep_req_reg) begin
                        sleep_n    <= 1'b1;
                        lowpwr_reg <= 1'b0;
                        cnt_reg    <= 11'h000;
                        if (lowpwr_reg && !cfg_live_reg[`PSI_CFG_SLEEP]) begin
                            state_reg <= ST_INIT;
                        end else begin
                            state_reg <= ST_IDLE;
                        end
                    end
                end
                ST_REL: begin
                    cmd_reg   <= 3'h0;
                    done_reg  <= 1'b1;
                    state_reg <= ST_IDLE;
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

endmodule // psi_ctrl

`default_nettype wire

// file: rtl/psi_defs.vh
`ifndef PSI_DEFS_VH
`define PSI_DEFS_VH

// Register byte offsets
`define PSI_OFS_CTRL    6'h00
`define PSI_OFS_ADDR    6'h04
`define PSI_OFS_WDATA   6'h08
`define PSI_OFS_RDATA   6'h0C
`define PSI_OFS_CFG     6'h10
`define PSI_OFS_STATUS  6'h14

// Control register fields
`define PSI_CTRL_RD     0
`define PSI_CTRL_WR     1
`define PSI_CTRL_CFG    2
`define PSI_CTRL_SLP    3

// Write data register fields
`define PSI_WD_LB       16
`define PSI_WD_UB       17

// Status register fields
`define PSI_ST_BUSY     0
`define PSI_ST_READY    1
`define PSI_ST_LOWPWR   2
`define PSI_ST_DONE     3

// Configuration bit choosing partial refresh over deep power-down
`define PSI_CFG_SLEEP   4
`define PSI_CFG_RESET   22'h000070

// Timing, in ns, and the clock period; sync depth in cycles
`define PSI_CLK_NS      100
`define PSI_ACC_NS      70
`define PSI_WE_NS       45
`define PSI_INIT_NS     150000
`define PSI_SLP_NS      10000
`define PSI_SYNC_CYC    2

// Cycle counts: least times round up, sleep entry must exceed its figure
`define PSI_ACC_CYC     ((`PSI_ACC_NS + `PSI_CLK_NS - 1) / `PSI_CLK_NS)
`define PSI_WE_CYC      ((`PSI_WE_NS + `PSI_CLK_NS - 1) / `PSI_CLK_NS)
`define PSI_INIT_CYC    ((`PSI_INIT_NS + `PSI_CLK_NS - 1) / `PSI_CLK_NS)
`define PSI_SLP_CYC     (`PSI_SLP_NS / `PSI_CLK_NS + 1)

// AXI responses
`define PSI_RESP_OK     2'h0
`define PSI_RESP_ERR    2'h2

`endif

// file: testbench/psi_ctrl_properties.sv
`timescale 1ns/1ps
`default_nettype none
module psi_ctrl_properties (
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic        chip_select_n,
    input wire logic        output_enable_n,
    input wire logic        write_enable_n,
    input wire logic        sleep_n,
    input wire logic [15:0] data_io_out,
    input wire logic        data_io_oe
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // Counts the start-up wait, saturating at 1500 cycles
    logic [10:0] init_cnt;
    always @(posedge ref_clk or posedge rst)
        if (rst) init_cnt <= 11'h000;
        else if (init_cnt != 11'h5DC) init_cnt <= init_cnt + 11'h001;
    a_init_quiet: assert property (init_cnt != 11'h5DC |-> chip_select_n)
        else $error("select low during start-up");
    a_read_shape: assert property (!output_enable_n |-> write_enable_n && sleep_n && !chip_select_n)
        else $error("read strobe with bad controls");
    a_read_len: assert property ($fell(output_enable_n) |-> !output_enable_n [*3] ##1 output_enable_n)
        else $error("read strobe length wrong");
    a_no_fight: assert property (data_io_oe |-> output_enable_n)
        else $error("bus driven during read strobe");
    a_write_sel: assert property (!write_enable_n |-> !chip_select_n)
        else $error("write strobe without select");
    a_we_short: assert property ($fell(write_enable_n) |-> ##[1:2] write_enable_n)
        else $error("write strobe too long");
    a_data_hold: assert property ($rose(write_enable_n) && sleep_n |-> data_io_oe && $stable(data_io_out))
        else $error("write data not held at strobe end");
    a_sleep_idle: assert property ($fell(sleep_n) |-> chip_select_n)
        else $error("sleep entered while selected");
    c_read: cover property ($rose(output_enable_n));
    c_write: cover property ($rose(write_enable_n) && sleep_n);
    c_cfg_load: cover property (!sleep_n && !write_enable_n);
endmodule // psi_ctrl_properties
bind psi_ctrl psi_ctrl_properties u_props (.ref_clk, .rst, .chip_select_n, .output_enable_n,
    .write_enable_n, .sleep_n, .data_io_out, .data_io_oe);
`default_nettype wire

// file: testbench/psi_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module psi_ctrl_tb;
    logic        ref_clk, rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_rready;
    logic [5:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, rd;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  rsp;
    wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire  [1:0]  s_axi_bresp, s_axi_rresp;
    wire  [31:0] s_axi_rdata;
    wire         chip_select_n, output_enable_n, write_enable_n, sleep_n, data_io_oe;
    wire         lower_byte_sel_n, upper_byte_sel_n;
    wire  [21:0] addr_in;
    wire  [15:0] data_io_out, data_io_in;
    integer      errors, cmp_count;
    psi_ctrl dut (.ref_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .chip_select_n, .output_enable_n, .write_enable_n, .lower_byte_sel_n,
        .upper_byte_sel_n, .sleep_n, .addr_in, .data_io_out, .data_io_oe, .data_io_in);
    psi_mem_model m (.chip_select_n, .output_enable_n, .write_enable_n, .lower_byte_sel_n,
        .upper_byte_sel_n, .sleep_n, .addr_in, .data_io_out, .data_io_oe, .data_io_in);
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    task end_of_test;
        $display("Compares %0d, errors %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task tmo;
        errors = errors + 1;
        $display("Error at %0t: wait ran out, seen %h expected %h", $time, 1'b0, 1'b1);
        end_of_test;
    endtask
    task chk(input [31:0] seen, input [31:0] exp);
        cmp_count = cmp_count + 1;
        if (seen !== exp) begin
            errors = errors + 1;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One register access; w selects write or read, handshakes held until taken
    task ax(input w, input [5:0] a, input [31:0] d);
        integer n;
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= w;
        s_axi_wvalid <= w;
        s_axi_bready <= w;
        s_axi_arvalid <= !w;
        s_axi_rready <= !w;
        for (n = 0; n < 64 && (n == 0 || s_axi_bready || s_axi_rready); n = n + 1) begin
            @(posedge ref_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready)) begin
                rsp = w ? s_axi_bresp : s_axi_rresp;
                rd = s_axi_rdata;
                s_axi_bready <= 1'b0;
                s_axi_rready <= 1'b0;
            end
        end
        if (s_axi_bready || s_axi_rready) tmo;
    endtask
    task poll(input integer b);
        integer n;
        rd = 32'h0;
        for (n = 0; n < 1000 && rd[b] !== 1'b1; n = n + 1) ax(1'b0, 6'h14, 32'h0);
        if (rd[b] !== 1'b1) tmo;
    endtask
    task go(input [31:0] c);
        ax(1'b1, 6'h14, 32'h8);
        ax(1'b1, 6'h00, c);
        poll(3);
    endtask
    task mw(input [21:0] a, input [17:0] d);
        ax(1'b1, 6'h04, {10'h0, a});
        ax(1'b1, 6'h08, {14'h0, d});
        go(32'h2);
    endtask
    task mr(input [21:0] a);
        ax(1'b1, 6'h04, {10'h0, a});
        ax(1'b1, 6'h08, 32'h30000);
        go(32'h1);
        ax(1'b0, 6'h0C, 32'h0);
    endtask
    initial begin
        errors = 0;
        cmp_count = 0;
        rst = 1'b1;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 44'h0;
        s_axi_wstrb = 4'hF;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        ax(1'b0, 6'h14, 32'h0);
        chk(rd & 32'h2, 32'h0);
        ax(1'b0, 6'h10, 32'h0);
        chk(rd, 32'h70);
        ax(1'b0, 6'h18, 32'h0);
        chk({rd[29:0], rsp}, 32'h2);
        ax(1'b1, 6'h1C, 32'h1);
        chk({30'h0, rsp}, 32'h2);
        poll(1);
        mw(22'h3FFFFF, 18'h31234);
        mw(22'h3FFFEF, 18'h35678);
        mw(22'h3FFFEF, 18'h1ABCD);
        mr(22'h3FFFFF);
        chk(rd & 32'hFFFF, 32'h1234);
        mr(22'h3FFFEF);
        chk(rd & 32'hFFFF, 32'h56CD);
        ax(1'b1, 6'h10, 32'h10);
        go(32'h4);
        chk({10'h0, m.config_reg}, 32'h10);
        ax(1'b1, 6'h00, 32'h8);
        poll(2);
        ax(1'b1, 6'h00, 32'h0);
        mr(22'h3FFFFF);
        chk(rd & 32'hFFFF, 32'h1234);
        chk({30'h0, m.mode}, 32'h1);
        ax(1'b1, 6'h10, 32'h0);
        go(32'h4);
        ax(1'b1, 6'h00, 32'h8);
        poll(2);
        ax(1'b1, 6'h00, 32'h0);
        ax(1'b0, 6'h14, 32'h0);
        chk(rd & 32'h2, 32'h0);
        chk({30'h0, m.mode}, 32'h2);
        poll(1);
        mw(22'h000005, 18'h3BEEF);
        mr(22'h000005);
        chk(rd & 32'hFFFF, 32'hBEEF);
        end_of_test;
    end
endmodule // psi_ctrl_tb
`default_nettype wire

// file: testbench/psi_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module psi_mem_model (
    input  wire logic        chip_select_n,
    input  wire logic        output_enable_n,
    input  wire logic        write_enable_n,
    input  wire logic        lower_byte_sel_n,
    input  wire logic        upper_byte_sel_n,
    input  wire logic        sleep_n,
    input  wire logic [21:0] addr_in,
    input  wire logic [15:0] data_io_out,
    input  wire logic        data_io_oe,
    output logic      [15:0] data_io_in
);
    // flat word store; refresh and page reads not modelled
    logic [15:0] mem [logic [21:0]];
    logic [21:0] config_reg = 22'h000070;
    logic [1:0]  mode = 2'h0;
    logic        avail, wl, wu;
    logic [21:0] wa;
    logic [15:0] wd, wv, rw, dv;
    realtime     slp_t = 0.0;
    // write enable wins over output enable
    wire wr_act = !chip_select_n && !write_enable_n && sleep_n && avail
        && !(lower_byte_sel_n && upper_byte_sel_n);
    wire cf_act = !chip_select_n && !write_enable_n && !sleep_n;
    wire rd_act = !chip_select_n && !output_enable_n && write_enable_n && sleep_n && avail;
    // data appears only after the access time
    wire #70 rd_ok = rd_act;
    // accesses ignored until start-up is over
    initial begin
        avail = 1'b0;
        #150000 avail = 1'b1;
    end
    always @* if (wr_act || cf_act)
        {wa, wd, wl, wu} = {addr_in, data_io_out, lower_byte_sel_n, upper_byte_sel_n};
    // commit at the first rising control, per byte
    // Skip the edge out of the unknown start-up level, nothing was latched then
    always @(negedge wr_act) if (!$isunknown(wa)) begin
        wv = mem.exists(wa) ? mem[wa] : 16'h0000;
        if (!wl) wv[7:0] = wd[7:0];
        if (!wu) wv[15:8] = wd[15:8];
        mem[wa] = wv;
    end
    always @(negedge cf_act) if (!$isunknown(wa)) config_reg = wa;
    always @(negedge sleep_n) slp_t = $realtime;
    // deep power-down loses data and restarts
    always @(posedge sleep_n) if (chip_select_n && $realtime - slp_t > 10000.0) begin
        mode = config_reg[4] ? 2'h1 : 2'h2;
        if (!config_reg[4]) begin
            mem.delete();
            avail = 1'b0;
            avail <= #150000 1'b1;
        end
    end
    // released bytes show the inverse so stale data cannot pass
    always @* begin
        rw = mem.exists(addr_in) ? mem[addr_in] : 16'h0000;
        dv = ~rw;
        if (rd_ok && rd_act && !lower_byte_sel_n) dv[7:0] = rw[7:0];
        if (rd_ok && rd_act && !upper_byte_sel_n) dv[15:8] = rw[15:8];
        data_io_in = data_io_oe ? data_io_out : dv;
    end
endmodule // psi_mem_model
`default_nettype wire
